// >>> core/hcfa_pkg.sv
package hcfa_pkg;

   //**********************************************
   // timing
   //**********************************************
   localparam int CLK_HZ          = 25000000;
   localparam int MIN_ON_MS       = 100;
   localparam int MIN_OFF_MS      = 100;
   localparam int FAST_ON_MS      = 30;
   localparam int FAST_OFF_MS     = 35;
   localparam int TICK_HZ         = 1000;
   localparam int TICK_CYCLES     = CLK_HZ / TICK_HZ;
   localparam int MS_W            = 8;

   //**********************************************
   // thresholds, units of 0.1 A
   //**********************************************
   localparam int          CUR_W   = 10;
   localparam logic [9:0]  THR_MIN = 10'h001;
   localparam logic [9:0]  THR_MAX = 10'h1F3;
   localparam logic [9:0]  THR_RST = 10'h001;
   localparam int          CT_N    = 2;

   typedef struct packed {
      logic [CUR_W-1:0] burnout;
      logic [CUR_W-1:0] ssr;
   } hcfa_thr_t;

   typedef struct packed {
      logic burnout;
      logic ssr;
   } hcfa_alarm_t;

   function automatic logic hcfa_thr_ok(input logic [CUR_W-1:0] v);
      return (v >= THR_MIN) && (v <= THR_MAX);
   endfunction

endpackage

// >>> core/hcfa_ms_tick.sv
`timescale 1ns/10ps
module hcfa_ms_tick
   import hcfa_pkg::*;
#(
   parameter int DIV = TICK_CYCLES   // clocks per tick
)
(
   input  wire logic clock,   // system clock
   input  wire logic rst_b,   // async reset
   output logic      tick     // 1 ms pulse
);

   localparam int CW = $clog2(DIV);
   localparam logic [CW-1:0] LAST = CW'(DIV - 1);

   logic [CW-1:0] count;
   wire           wrap = (count == LAST);

   always_ff @(posedge clock or negedge rst_b)
      if (!rst_b)
      begin
         count <= '0;
         tick  <= 1'b0;
      end
      else
      begin
         count <= wrap ? '0 : count + 1'b1;
         tick  <= wrap;
      end

endmodule // hcfa_ms_tick

// >>> core/hcfa_core.sv
`timescale 1ns/10ps
module hcfa_core
   import hcfa_pkg::*;
#(
   parameter bit THREE_PHASE = 1'b1,        // two ct inputs when set
   parameter int MS_CYCLES   = TICK_CYCLES  // clocks per 1 ms tick
)
(
   input  wire logic             clock,      // 25 MHz clock
   input  wire logic             rst_b,      // async reset, low
   input  wire logic             ctrl_out,   // control output state
   input  wire logic             fast_period,// period is 0.1 s or 0.2 s
   input  wire logic             thr_we,     // threshold write strobe
   input  wire hcfa_thr_t        thr_wdata,  // thresholds to write
   output logic                  thr_reject, // last write refused
   input  wire logic [CUR_W-1:0] ct_a,       // ct input 1, 0.1 A units
   input  wire logic [CUR_W-1:0] ct_b,       // ct input 2, 0.1 A units
   input  wire logic             ct_valid,   // new current sample
   output hcfa_alarm_t           alarm       // alarm outputs
);

   //**********************************************
   // helper functions
   //**********************************************
   function automatic logic cur_below
   (
      input logic [CUR_W-1:0] cur,
      input logic [CUR_W-1:0] limit
   );
      return cur < limit;
   endfunction

   function automatic logic cur_above
   (
      input logic [CUR_W-1:0] cur,
      input logic [CUR_W-1:0] limit
   );
      return cur > limit;
   endfunction

   // the tick runs free and may land just after a change, so one
   // extra tick guarantees the full minimum duration
   function automatic logic dur_met
   (
      input logic [MS_W-1:0] dur,
      input logic [MS_W-1:0] need
   );
      return dur > need;
   endfunction

   //**********************************************
   // threshold settings
   //**********************************************
   hcfa_thr_t thr;
   hcfa_thr_t next_thr;
   logic      next_reject;

   wire bo_ok   = hcfa_thr_ok(thr_wdata.burnout);
   wire ssr_ok  = hcfa_thr_ok(thr_wdata.ssr);
   wire wr_ok   = bo_ok && ssr_ok;
   wire wr_take = thr_we && wr_ok;

   assign next_thr    = wr_take ? thr_wdata : thr;
   assign next_reject = thr_we ? !wr_ok : thr_reject;

   always_ff @(posedge clock or negedge rst_b)
      if (!rst_b)
      begin
         thr <= '{burnout: THR_RST, ssr: THR_RST};
      end
      else
      begin
         thr <= next_thr;
      end

   always_ff @(posedge clock or negedge rst_b)
      if (!rst_b)
      begin
         thr_reject <= 1'b0;
      end
      else
      begin
         thr_reject <= next_reject;
      end

   //**********************************************
   // control output synchroniser
   //**********************************************
   logic ctrl_s1;
   logic ctrl_s2;
   logic ctrl_q;

   always_ff @(posedge clock or negedge rst_b)
      if (!rst_b)
      begin
         ctrl_s1 <= 1'b0;
         ctrl_s2 <= 1'b0;
      end
      else
      begin
         ctrl_s1 <= ctrl_out;
         ctrl_s2 <= ctrl_s1;
      end

   always_ff @(posedge clock or negedge rst_b)
      if (!rst_b)
      begin
         ctrl_q <= 1'b0;
      end
      else
      begin
         ctrl_q <= ctrl_s2;
      end

   //**********************************************
   // output state duration in ms
   //**********************************************
   logic            tick;
   logic [MS_W-1:0] dur_ms;
   logic [MS_W-1:0] next_dur;

   hcfa_ms_tick
   #(
      .DIV   (MS_CYCLES)
   )
   u_tick
   (
      .clock (clock),
      .rst_b (rst_b),
      .tick  (tick)
   );

   wire changed = (ctrl_s2 != ctrl_q);
   wire sat     = (dur_ms == {MS_W{1'b1}});
   wire dur_inc = tick && !sat;

   assign next_dur = changed ? '0
                   : dur_inc ? dur_ms + 1'b1
                   : dur_ms;

   always_ff @(posedge clock or negedge rst_b)
      if (!rst_b)
      begin
         dur_ms <= '0;
      end
      else
      begin
         dur_ms <= next_dur;
      end

   //**********************************************
   // qualification windows
   //**********************************************
   wire [MS_W-1:0] on_need  = fast_period ? MS_W'(FAST_ON_MS)
                                          : MS_W'(MIN_ON_MS);
   wire [MS_W-1:0] off_need = fast_period ? MS_W'(FAST_OFF_MS)
                                          : MS_W'(MIN_OFF_MS);

   wire on_long  = dur_met(dur_ms, on_need);
   wire off_long = dur_met(dur_ms, off_need);
   wire on_win   = ctrl_q && !changed && on_long;
   wire off_win  = !ctrl_q && !changed && off_long;
   wire on_take  = ct_valid && on_win;
   wire off_take = ct_valid && off_win;

   //**********************************************
   // comparisons
   //**********************************************
   wire use_b    = THREE_PHASE;
   wire low_a    = cur_below(ct_a, thr.burnout);
   wire low_b    = use_b && cur_below(ct_b, thr.burnout);
   wire high_a   = cur_above(ct_a, thr.ssr);
   wire high_b   = use_b && cur_above(ct_b, thr.ssr);
   wire burn_now = low_a || low_b;
   wire ssr_now  = high_a || high_b;

   //**********************************************
   // alarm outputs
   //**********************************************
   hcfa_alarm_t next_alarm;

   assign next_alarm.burnout = on_take ? burn_now : alarm.burnout;
   assign next_alarm.ssr     = off_take ? ssr_now : alarm.ssr;

   always_ff @(posedge clock or negedge rst_b)
      if (!rst_b)
      begin
         alarm <= '0;
      end
      else
      begin
         alarm <= next_alarm;
      end

endmodule // hcfa_core

// >>> verif/hcfa_core_properties.sv
`timescale 1ns/10ps
module hcfa_core_chk
   import hcfa_pkg::*;
(
   input wire logic        clock,      // clock
   input wire logic        rst_b,      // reset
   input wire logic        ctrl_out,   // output on
   input wire logic        thr_we,     // write
   input wire hcfa_thr_t   thr_wdata,  // limits
   input wire logic        thr_reject, // refused
   input wire logic        ct_valid,   // sample
   input wire hcfa_alarm_t alarm       // alarms
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_b);
   wire b_bad = thr_wdata.burnout < THR_MIN || thr_wdata.burnout > THR_MAX;
   wire s_bad = thr_wdata.ssr < THR_MIN || thr_wdata.ssr > THR_MAX;
   property p_brej; thr_we && b_bad |=> thr_reject; endproperty
   a_brej: assert property (p_brej) else $error("no reject");
   property p_srej; thr_we && s_bad |=> thr_reject; endproperty
   a_srej: assert property (p_srej) else $error("no reject");
   property p_ok; thr_we && !b_bad && !s_bad |=> !thr_reject; endproperty
   a_ok: assert property (p_ok) else $error("bad reject");
   property p_rhold; !thr_we |=> $stable(thr_reject); endproperty
   a_rhold: assert property (p_rhold) else $error("flag moved");
   property p_hold; !ct_valid |=> $stable(alarm); endproperty
   a_hold: assert property (p_hold) else $error("alarm moved");
   property p_bon;
      $rose(alarm.burnout) |-> $past(ct_valid) && $past(ctrl_out, 4);
   endproperty
   a_bon: assert property (p_bon) else $error("burnout cause");
   property p_son;
      $rose(alarm.ssr) |-> $past(ct_valid) && !$past(ctrl_out, 4);
   endproperty
   a_son: assert property (p_son) else $error("ssr cause");
   property p_boff; $fell(alarm.burnout) |-> $past(ctrl_out, 4); endproperty
   a_boff: assert property (p_boff) else $error("burnout clear");
endmodule // hcfa_core_chk

bind hcfa_core hcfa_core_chk u_chk (.clock, .rst_b, .ctrl_out, .thr_we,
   .thr_wdata, .thr_reject, .ct_valid, .alarm);

// >>> verif/hcfa_ct_model.sv
`timescale 1ns/10ps
module hcfa_ct_model
   import hcfa_pkg::*;
(
   input  wire logic             clock,   // clock
   input  wire logic [CUR_W-1:0] cur,     // phase 1 current
   input  wire logic [CUR_W-1:0] cur_b,   // phase 2 current
   input  wire logic             vld,     // sampling enabled
   output logic      [CUR_W-1:0] ct_a,    // phase 1
   output logic      [CUR_W-1:0] ct_b,    // phase 2
   output logic                  ct_valid // sample
);
   always_ff @(posedge clock)
   begin
      ct_a     <= cur;
      ct_b     <= cur_b;
      ct_valid <= vld;
   end
endmodule // hcfa_ct_model

// >>> verif/heater_current_fault_alarm_tb.sv
`timescale 1ns/10ps
module heater_current_fault_alarm_tb;
   import hcfa_pkg::*;
   localparam int    MS = 20; // clocks per simulated millisecond
   logic             clock = 0, rst_b = 0, ctrl_out = 0, fast = 0, we = 0;
   logic             vld = 0;
   hcfa_thr_t        wd = '0;
   logic [CUR_W-1:0] cur = '0, cur_b = '0, ct_a, ct_b;
   logic             ct_valid, thr_reject;
   hcfa_alarm_t      alarm;
   int               error_cnt = 0, n_compared = 0;
   logic [9:0]       v[4] = '{10'h000, 10'h001, 10'h1F3, 10'h1F4};
   always #20 clock = ~clock;
   hcfa_ct_model u_ct (.clock, .cur, .cur_b, .vld, .ct_a, .ct_b, .ct_valid);
   hcfa_core #(.MS_CYCLES(MS)) uut (.clock, .rst_b, .ctrl_out,
      .fast_period(fast), .thr_we(we), .thr_wdata(wd), .thr_reject, .ct_a,
      .ct_b, .ct_valid, .alarm);
   task automatic ms(int n);
      repeat (n * MS) @(posedge clock);
      @(negedge clock);
   endtask
   task automatic settle;
      repeat (3) @(posedge clock);
      @(negedge clock);
   endtask
   task automatic compare(logic [1:0] got, logic [1:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("Error t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(logic [9:0] b, logic [9:0] s, logic bad);
      @(posedge clock);
      we <= 1'h1;
      wd <= '{b, s};
      @(posedge clock);
      we <= 1'h0;
      @(negedge clock);
      compare({1'h0, thr_reject}, {1'h0, bad});
   endtask
   task automatic t_thr;
      for (int i = 0; i < 4; i++)
      begin
         wr(v[i], 10'h064, v[i] < THR_MIN || v[i] > THR_MAX);
         wr(10'h064, v[i], v[i] < THR_MIN || v[i] > THR_MAX);
      end
   endtask
   task automatic t_on_slow;
      wr(10'h064, 10'h00A, 1'h0);
      @(posedge clock);
      cur      <= 10'h005;
      cur_b    <= 10'h080;
      vld      <= 1'h1;
      ctrl_out <= 1'h1;
      ms(99);
      compare(alarm, 2'h0);
      ms(4);
      compare(alarm, 2'h2);
      @(posedge clock);
      cur <= 10'h080;
      settle();
      compare(alarm, 2'h0);
      @(posedge clock);
      cur_b <= 10'h005;
      settle();
      compare(alarm, 2'h2);
      @(posedge clock);
      vld   <= 1'h0;
      cur_b <= 10'h080;
      settle();
      compare(alarm, 2'h2);
      @(posedge clock);
      vld <= 1'h1;
      settle();
      compare(alarm, 2'h0);
   endtask
   task automatic t_off_slow;
      @(posedge clock);
      ctrl_out <= 1'h0;
      ms(99);
      compare(alarm, 2'h0);
      ms(4);
      compare(alarm, 2'h1);
   endtask
   task automatic t_fast;
      @(posedge clock);
      fast     <= 1'h1;
      ctrl_out <= 1'h1;
      ms(1);
      @(posedge clock);
      cur   <= 10'h005;
      cur_b <= 10'h005;
      ms(28);
      compare(alarm, 2'h1);
      ms(4);
      compare(alarm, 2'h3);
      @(posedge clock);
      ctrl_out <= 1'h0;
      ms(34);
      compare(alarm, 2'h3);
      ms(4);
      compare(alarm, 2'h2);
   endtask
   task automatic t_rst;
      @(posedge clock);
      rst_b <= 1'h0;
      repeat (2) @(posedge clock);
      rst_b <= 1'h1;
      @(negedge clock);
      compare(alarm, 2'h0);
      compare({1'h0, thr_reject}, 2'h0);
   endtask
   task automatic complete_run;
      $display("compared %0d errors %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial
   begin
      #400000; // about 10000 clocks, tests need under 6000
      error_cnt++;
      complete_run();
   end
   initial
   begin
      repeat (6) @(posedge clock);
      rst_b <= 1'h1;
      @(negedge clock);
      compare(alarm, 2'h0);
      t_thr();
      t_on_slow();
      t_off_slow();
      t_fast();
      t_rst();
      complete_run();
   end
endmodule // heater_current_fault_alarm_tb
